// >>> rtl/mls_pkg.sv
// Package: constants and register map of the mechanical load shedding element
package mls_pkg;

  // ***********************************************************************
  // Register offsets (byte addresses on classic Wishbone)
  // ***********************************************************************
  localparam logic [7:0] MLS_CTRL_OFS     = 8'h00;
  localparam logic [7:0] MLS_PICKUP_OFS   = 8'h04;
  localparam logic [7:0] MLS_RELEASE_OFS  = 8'h08;
  localparam logic [7:0] MLS_TPICK_OFS    = 8'h0c;
  localparam logic [7:0] MLS_TREL_OFS     = 8'h10;
  localparam logic [7:0] MLS_FLA_OFS      = 8'h14;
  localparam logic [7:0] MLS_STATE_OFS    = 8'h18;
  localparam logic [7:0] MLS_IRQ_STAT_OFS = 8'h1c;
  localparam logic [7:0] MLS_IRQ_CLR_OFS  = 8'h20;
  localparam logic [7:0] MLS_IRQ_EN_OFS   = 8'h24;

  // ***********************************************************************
  // Control register fields
  // ***********************************************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_ALLOW_BIT  = 1;
  localparam int CTRL_ASSIGN1_BIT = 2;
  localparam int CTRL_ASSIGN2_BIT = 3;

  // State register fields
  localparam int ST_ACTIVE_BIT  = 0;
  localparam int ST_BLOCKED_BIT = 1;
  localparam int ST_ALARM_BIT   = 2;
  localparam int ST_TRIP_BIT    = 3;
  localparam int ST_IN1_BIT     = 4;
  localparam int ST_IN2_BIT     = 5;

  // Interrupt events: alarm rise, trip rise, trip fall, block rise
  localparam int IRQ_W = 4;

  // ***********************************************************************
  // Reset values; levels are hundredths of rated full load current
  // ***********************************************************************
  localparam logic [3:0]  CTRL_RST      = 4'h0;
  localparam logic [7:0]  PICKUP_RST    = 8'h5a;   // 0.90
  localparam logic [7:0]  RELEASE_RST   = 8'h32;   // 0.50
  localparam logic [7:0]  LEVEL_MIN     = 8'h32;   // 0.50
  localparam logic [7:0]  LEVEL_MAX     = 8'h96;   // 1.50
  localparam logic [15:0] FLA_RST       = 16'h0400;
  localparam logic [5:0]  TIME_MAX      = 6'h32;   // 5.0 s in tenths
  localparam logic [5:0]  TIME_RST      = 6'h0a;   // 1.0 s in tenths

  // ***********************************************************************
  // Timing: delays are set in tenths of a second
  // ***********************************************************************
  localparam int CLK_HZ        = 10_000_000;
  localparam int TICK_MS       = 100;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

endpackage : mls_pkg

// >>> rtl/mls_load_shed.sv
// Mechanical load shedding element with Wishbone register slave
// Summary of operation
// - Shed contact operates when load exceeds pickup
// - Act only after pickup time elapsed
// - Hold shed output until below release
// - Release output after release time elapsed
// - Operate only while motor is running
// - Enable setting activates whole element
// - Two assignable external block inputs
// - Allow setting permits external blocking
// - Pickup level 0.50 to 1.50 rated
// - Release level 0.50 to 1.50 rated
// - Expose live state of block inputs
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
module mls_load_shed #(
  parameter int TICK_CYCLES = mls_pkg::TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] phase_a_current_i,
  input  wire logic [15:0] phase_b_current_i,
  input  wire logic [15:0] phase_c_current_i,
  input  wire logic        motor_running_i,
  input  wire logic        external_block_input_one_i,
  input  wire logic        external_block_input_two_i,
  output logic             shed_contact_o,
  output logic             active_o,
  output logic             externally_blocked_flag_o,
  output logic             alarm_o,
  output logic             trip_o,
  output logic             block_one_state_o,
  output logic             block_two_state_o,
  output logic             irq_o
);

  typedef enum logic [1:0] {
    MLS_IDLE,
    MLS_PICKING,
    MLS_SHEDDING,
    MLS_RELEASING
  } mls_state_type;

  // ***********************************************************************
  // Settings registers
  // ***********************************************************************
  logic [3:0]  ctrl_q;
  logic [7:0]  pickup_q;
  logic [7:0]  release_q;
  logic [5:0]  tpick_q;
  logic [5:0]  trel_q;
  localparam int IRQ_W_L = mls_pkg::IRQ_W;
  logic [15:0] fla_q;
  logic [IRQ_W_L-1:0] irq_stat_q;
  logic [IRQ_W_L-1:0] irq_en_q;

  // Clamp a written level into the settable range
  function automatic logic [7:0] mls_clamp_level(input logic [7:0] v);
    if (v < mls_pkg::LEVEL_MIN) begin
      return mls_pkg::LEVEL_MIN;
    end else if (v > mls_pkg::LEVEL_MAX) begin
      return mls_pkg::LEVEL_MAX;
    end else begin
      return v;
    end
  endfunction : mls_clamp_level

  // Clamp a written delay to 5.0 s
  function automatic logic [5:0] mls_clamp_time(input logic [7:0] v);
    if (v > {2'b00, mls_pkg::TIME_MAX}) begin
      return mls_pkg::TIME_MAX;
    end else begin
      return v[5:0];
    end
  endfunction : mls_clamp_time

  // ***********************************************************************
  // Bus decode
  // ***********************************************************************
  wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_ctrl   = bus_wr & (wb_adr_i == mls_pkg::MLS_CTRL_OFS);
  wire wr_pick   = bus_wr & (wb_adr_i == mls_pkg::MLS_PICKUP_OFS);
  wire wr_rel    = bus_wr & (wb_adr_i == mls_pkg::MLS_RELEASE_OFS);
  wire wr_tpick  = bus_wr & (wb_adr_i == mls_pkg::MLS_TPICK_OFS);
  wire wr_trel   = bus_wr & (wb_adr_i == mls_pkg::MLS_TREL_OFS);
  wire wr_fla    = bus_wr & (wb_adr_i == mls_pkg::MLS_FLA_OFS);
  wire wr_clr    = bus_wr & (wb_adr_i == mls_pkg::MLS_IRQ_CLR_OFS);
  wire wr_irqen  = bus_wr & (wb_adr_i == mls_pkg::MLS_IRQ_EN_OFS);
  wire wr_fla_hi = wr_fla & wb_sel_i[1];

  // Settings writes; levels and times clamped to their legal range
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q    <= mls_pkg::CTRL_RST;
      pickup_q  <= mls_pkg::PICKUP_RST;
      release_q <= mls_pkg::RELEASE_RST;
      tpick_q   <= mls_pkg::TIME_RST;
      trel_q    <= mls_pkg::TIME_RST;
      fla_q     <= mls_pkg::FLA_RST;
      irq_en_q  <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wb_dat_i[3:0];
      end
      if (wr_pick) begin
        pickup_q <= mls_clamp_level(wb_dat_i[7:0]);
      end
      if (wr_rel) begin
        release_q <= mls_clamp_level(wb_dat_i[7:0]);
      end
      if (wr_tpick) begin
        tpick_q <= mls_clamp_time(wb_dat_i[7:0]);
      end
      if (wr_trel) begin
        trel_q <= mls_clamp_time(wb_dat_i[7:0]);
      end
      if (wr_fla) begin
        fla_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_fla_hi) begin
        fla_q[15:8] <= wb_dat_i[15:8];
      end
      if (wr_irqen) begin
        irq_en_q <= wb_dat_i[IRQ_W_L-1:0];
      end
    end
  end

  // ***********************************************************************
  // Threshold comparison
  // ***********************************************************************
  // Thresholds in current units: level/100 times rated full load current
  wire [23:0] pick_prod = pickup_q * fla_q;
  wire [23:0] rel_prod  = release_q * fla_q;
  wire [23:0] ia_x100   = 24'(phase_a_current_i) * 24'h000064;
  wire [23:0] ib_x100   = 24'(phase_b_current_i) * 24'h000064;
  wire [23:0] ic_x100   = 24'(phase_c_current_i) * 24'h000064;

  // Any phase over pickup; all phases under release
  wire over_pick  = (ia_x100 > pick_prod) | (ib_x100 > pick_prod) | (ic_x100 > pick_prod);
  wire under_rel  = (ia_x100 < rel_prod) & (ib_x100 < rel_prod) & (ic_x100 < rel_prod);

  // ***********************************************************************
  // Qualification
  // ***********************************************************************
  wire enabled  = ctrl_q[mls_pkg::CTRL_ENABLE_BIT];
  // Blocking only counts for an assigned input and when allowed
  wire blk_one  = ctrl_q[mls_pkg::CTRL_ASSIGN1_BIT] & external_block_input_one_i;
  wire blk_two  = ctrl_q[mls_pkg::CTRL_ASSIGN2_BIT] & external_block_input_two_i;
  wire blocked  = enabled & ctrl_q[mls_pkg::CTRL_ALLOW_BIT] & (blk_one | blk_two);
  wire active   = enabled & ~blocked;
  wire evaluate = active & motor_running_i;

  // ***********************************************************************
  // Timer: 100 ms tick prescaler and tenth-second counter
  // ***********************************************************************
  mls_state_type state_q;
  mls_state_type state_d;
  logic [23:0]   pre_q;
  logic [5:0]    tenths_q;
  wire           timing  = (state_q == MLS_PICKING) | (state_q == MLS_RELEASING);
  wire           tick    = (pre_q == 24'(TICK_CYCLES - 1));
  wire [5:0]     target  = (state_q == MLS_PICKING) ? tpick_q : trel_q;
  wire           expired = (tenths_q >= target);

  // Prescaler restarts whenever a delay starts, so delays are exact
  always_ff @(posedge clk_i) begin
    if (rst_i || !timing || state_d != state_q) begin
      pre_q    <= '0;
      tenths_q <= '0;
    end else if (tick) begin
      pre_q    <= '0;
      tenths_q <= tenths_q + 6'h01;
    end else begin
      pre_q    <= pre_q + 24'h000001;
    end
  end

  // ***********************************************************************
  // Shedding sequence
  // ***********************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      MLS_IDLE: begin
        if (over_pick) state_d = MLS_PICKING;
      end
      MLS_PICKING: begin
        if (!over_pick) state_d = MLS_IDLE;
        else if (expired) state_d = MLS_SHEDDING;
      end
      MLS_SHEDDING: begin
        if (under_rel) state_d = MLS_RELEASING;
      end
      MLS_RELEASING: begin
        if (!under_rel) state_d = MLS_SHEDDING;
        else if (expired) state_d = MLS_IDLE;
      end
      default: state_d = MLS_IDLE;
    endcase
    if (!evaluate) state_d = MLS_IDLE;
  end

  // State register; reset lands in idle with the contact open
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= MLS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ***********************************************************************
  // Status outputs, registered
  // ***********************************************************************
  wire alarm_d = (state_d != MLS_IDLE);
  wire trip_d  = (state_d == MLS_SHEDDING) | (state_d == MLS_RELEASING);

  // Outputs follow the next state so they lag the inputs by one edge only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_o                  <= 1'b0;
      externally_blocked_flag_o <= 1'b0;
      alarm_o                   <= 1'b0;
      trip_o                    <= 1'b0;
      shed_contact_o            <= 1'b0;
      block_one_state_o         <= 1'b0;
      block_two_state_o         <= 1'b0;
    end else begin
      active_o                  <= active;
      externally_blocked_flag_o <= blocked;
      alarm_o                   <= alarm_d;
      trip_o                    <= trip_d;
      shed_contact_o            <= trip_d;
      block_one_state_o         <= external_block_input_one_i;
      block_two_state_o         <= external_block_input_two_i;
    end
  end

  // ***********************************************************************
  // Interrupts: set wins over a clear in the same cycle
  // ***********************************************************************
  wire [IRQ_W_L-1:0] irq_evt = {blocked & ~externally_blocked_flag_o,
                                ~trip_d & trip_o,
                                trip_d & ~trip_o,
                                alarm_d & ~alarm_o};
  wire [IRQ_W_L-1:0] irq_clr = wr_clr ? wb_dat_i[IRQ_W_L-1:0] : '0;
  // Next status; an event in the clearing cycle survives the clear
  wire [IRQ_W_L-1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;

  // Level request built from the next status, so it tracks the register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_o      <= |(irq_stat_d & irq_en_q);
    end
  end

  // ***********************************************************************
  // Read mux; unmapped addresses read zero and still acknowledge
  // ***********************************************************************
  wire [31:0] state_word = {26'h0, block_two_state_o, block_one_state_o,
                            trip_o, alarm_o, externally_blocked_flag_o, active_o};
  logic [31:0] rd_data;

  // Address decode of the read word; the clear register reads as zero
  always_comb begin
    if (wb_adr_i == mls_pkg::MLS_CTRL_OFS) rd_data = {28'h0, ctrl_q};
    else if (wb_adr_i == mls_pkg::MLS_PICKUP_OFS) rd_data = {24'h0, pickup_q};
    else if (wb_adr_i == mls_pkg::MLS_RELEASE_OFS) rd_data = {24'h0, release_q};
    else if (wb_adr_i == mls_pkg::MLS_TPICK_OFS) rd_data = {26'h0, tpick_q};
    else if (wb_adr_i == mls_pkg::MLS_TREL_OFS) rd_data = {26'h0, trel_q};
    else if (wb_adr_i == mls_pkg::MLS_FLA_OFS) rd_data = {16'h0, fla_q};
    else if (wb_adr_i == mls_pkg::MLS_STATE_OFS) rd_data = state_word;
    else if (wb_adr_i == mls_pkg::MLS_IRQ_STAT_OFS) rd_data = {28'h0, irq_stat_q};
    else if (wb_adr_i == mls_pkg::MLS_IRQ_EN_OFS) rd_data = {28'h0, irq_en_q};
    else rd_data = 32'h0;
  end

  // One-cycle ack, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h0;
    end
  end

endmodule : mls_load_shed

// >>> sim/mls_load_shed_assertions.sv
// Checker: concurrent properties on the load shedding element ports
module mls_load_shed_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        motor_running_i,
  input wire logic        external_block_input_one_i,
  input wire logic        external_block_input_two_i,
  input wire logic        shed_contact_o,
  input wire logic        active_o,
  input wire logic        externally_blocked_flag_o,
  input wire logic        alarm_o,
  input wire logic        trip_o,
  input wire logic        block_one_state_o,
  input wire logic        block_two_state_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************************************************************
  // Bus handshake and protection outputs
  // ***********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data present without ack");
  shed_trip_a: assert property (shed_contact_o == trip_o)
    else $error("contact differs from trip");
  run_gate_a: assert property (!motor_running_i |=> !alarm_o && !trip_o)
    else $error("output while motor not running");
  // Blocking is registered, so allow the first blocked cycle to settle
  block_quiet_a: assert property (
    externally_blocked_flag_o && $past(externally_blocked_flag_o)
    |-> !alarm_o && !trip_o && !active_o) else $error("output while blocked");
  block_cause_a: assert property ($rose(externally_blocked_flag_o) |->
    $past(external_block_input_one_i || external_block_input_two_i))
    else $error("block without input");
  in_one_a: assert property (!$past(rst_i) |->
    block_one_state_o == $past(external_block_input_one_i))
    else $error("input one state wrong");
  in_two_a: assert property (!$past(rst_i) |->
    block_two_state_o == $past(external_block_input_two_i))
    else $error("input two state wrong");
  trip_order_a: assert property ($rose(trip_o) |-> $past(alarm_o))
    else $error("trip without preceding alarm");
  idle_quiet_a: assert property (!active_o && $past(!active_o) |-> !alarm_o && !trip_o)
    else $error("output while inactive");
endmodule : mls_load_shed_assertions

// >>> sim/mls_process_model.sv
// Process feed model driven by the load shed contact
module mls_process_model (
  input  wire logic clk_i,
  input  wire logic shed_i,
  output logic      feed_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Feed stops while the contact is held; plant reacts one cycle late
  always @(posedge clk_i) begin
    feed_o <= !shed_i;
  end
endmodule : mls_process_model

// >>> sim/tb_mls_load_shed.sv
// Testbench of the mechanical load shedding element
module tb_mls_load_shed;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 10;  // Short tick keeps delays a few dozen cycles
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [15:0] phase_a_current_i = 16'h0, phase_b_current_i = 16'h0;
  logic [15:0] phase_c_current_i = 16'h0;
  logic        motor_running_i = 1'b0;
  logic        external_block_input_one_i = 1'b0, external_block_input_two_i = 1'b0;
  logic        wb_ack_o, shed_contact_o, active_o, externally_blocked_flag_o, alarm_o, trip_o;
  logic        block_one_state_o, block_two_state_o, irq_o, feed;
  int          error_cnt = 0, n_tests = 0, n;

  mls_load_shed #(
    .TICK_CYCLES(TICK)
  ) i_mls_load_shed (
    .clk_i                      (clk_i),
    .rst_i                      (rst_i),
    .wb_cyc_i                   (wb_cyc_i),
    .wb_stb_i                   (wb_stb_i),
    .wb_we_i                    (wb_we_i),
    .wb_adr_i                   (wb_adr_i),
    .wb_sel_i                   (wb_sel_i),
    .wb_dat_i                   (wb_dat_i),
    .wb_dat_o                   (wb_dat_o),
    .wb_ack_o                   (wb_ack_o),
    .phase_a_current_i          (phase_a_current_i),
    .phase_b_current_i          (phase_b_current_i),
    .phase_c_current_i          (phase_c_current_i),
    .motor_running_i            (motor_running_i),
    .external_block_input_one_i (external_block_input_one_i),
    .external_block_input_two_i (external_block_input_two_i),
    .shed_contact_o             (shed_contact_o),
    .active_o                   (active_o),
    .externally_blocked_flag_o  (externally_blocked_flag_o),
    .alarm_o                    (alarm_o),
    .trip_o                     (trip_o),
    .block_one_state_o          (block_one_state_o),
    .block_two_state_o          (block_two_state_o),
    .irq_o                      (irq_o)
  );
  mls_process_model i_mls_process_model (.clk_i(clk_i), .shed_i(shed_contact_o), .feed_o(feed));

  initial forever #50 clk_i = ~clk_i;

  // ***********************************************************************
  // Shared tasks
  // ***********************************************************************
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic e, input logic a);
    n_tests++;
    if (a !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, a);
    end
  endtask : chk

  // Request held until ack is sampled high, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    chk("ack", 1'b1, wb_ack_o);
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    n_tests++;
    if (q !== e) begin
      error_cnt++;
      $display("ERROR reg %h expected %h seen %h", a, e, q);
    end
  endtask : rchk

  // Bounded wait on falling edges for alarm (w 0) or trip (w 1)
  task automatic wait_for(input bit w, input logic v, input int mx);
    n = 0;
    @(negedge clk_i);
    while ((w ? trip_o : alarm_o) !== v && n < mx) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_for

  task automatic set_i(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk_i);
    {phase_a_current_i, phase_b_current_i, phase_c_current_i} <= {a, b, c};
  endtask : set_i

  // ***********************************************************************
  // Scenarios
  // ***********************************************************************
  task automatic t_defaults();
    rchk(mls_pkg::MLS_CTRL_OFS, 32'h0);
    rchk(mls_pkg::MLS_PICKUP_OFS, 32'h5a);
    rchk(mls_pkg::MLS_RELEASE_OFS, 32'h32);
    rchk(mls_pkg::MLS_TPICK_OFS, 32'h0a);
    rchk(mls_pkg::MLS_TREL_OFS, 32'h0a);
    rchk(8'h3c, 32'h0);
    bus(1'b1, mls_pkg::MLS_FLA_OFS, 32'h64);  // Currents now read as percent
    set_i(16'h00c8, 16'h00c8, 16'h00c8);
    motor_running_i <= 1'b1;
    wait_for(1'b0, 1'b1, 20);
    chk("alarm disabled", 1'b0, alarm_o);
    bus(1'b1, mls_pkg::MLS_PICKUP_OFS, 32'h10);
    rchk(mls_pkg::MLS_PICKUP_OFS, 32'h32);
    bus(1'b1, mls_pkg::MLS_PICKUP_OFS, 32'hff);
    rchk(mls_pkg::MLS_PICKUP_OFS, 32'h96);
    bus(1'b1, mls_pkg::MLS_TPICK_OFS, 32'h3f);
    rchk(mls_pkg::MLS_TPICK_OFS, 32'h32);
    bus(1'b1, mls_pkg::MLS_RELEASE_OFS, 32'hc8);
    rchk(mls_pkg::MLS_RELEASE_OFS, 32'h96);
    bus(1'b1, mls_pkg::MLS_RELEASE_OFS, 32'h32);
    bus(1'b1, mls_pkg::MLS_PICKUP_OFS, 32'h5a);  // Release stays well below
    bus(1'b1, mls_pkg::MLS_TPICK_OFS, 32'h02);
    bus(1'b1, mls_pkg::MLS_TREL_OFS, 32'h02);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_shed();
    set_i(16'h0, 16'h0, 16'h0);
    bus(1'b1, mls_pkg::MLS_CTRL_OFS, 32'h1);
    set_i(16'h0, 16'h005b, 16'h0);  // Only one phase just above pickup
    wait_for(1'b0, 1'b1, 10);
    chk("alarm", 1'b1, alarm_o);
    chk("active", 1'b1, active_o);
    wait_for(1'b1, 1'b1, 40);
    chk("pick delay", 1'b1, n >= 17 && n <= 24);
    chk("shed", 1'b1, shed_contact_o);
    set_i(16'h0, 16'h003c, 16'h0);  // Between release and pickup
    repeat (30) @(negedge clk_i);
    chk("shed held", 1'b1, trip_o);
    chk("feed stopped", 1'b0, feed);
    set_i(16'h0, 16'h0028, 16'h0);
    wait_for(1'b1, 1'b0, 40);
    chk("drop delay", 1'b1, n >= 17 && n <= 25);
    @(negedge clk_i);
    chk("feed resumed", 1'b1, feed);
    rchk(mls_pkg::MLS_IRQ_STAT_OFS, 32'h7);
    chk("irq masked", 1'b0, irq_o);
    bus(1'b1, mls_pkg::MLS_IRQ_EN_OFS, 32'hf);
    @(negedge clk_i);
    chk("irq", 1'b1, irq_o);
    bus(1'b1, mls_pkg::MLS_IRQ_CLR_OFS, 32'hf);
    rchk(mls_pkg::MLS_IRQ_STAT_OFS, 32'h0);
    chk("irq cleared", 1'b0, irq_o);
    $display("test shed done");
  endtask : t_shed

  task automatic t_run_block();
    set_i(16'h005f, 16'h0, 16'h0);
    motor_running_i <= 1'b0;
    wait_for(1'b0, 1'b1, 30);
    chk("alarm stopped", 1'b0, alarm_o);
    @(posedge clk_i);
    {motor_running_i, external_block_input_one_i, external_block_input_two_i} <= 3'b111;
    bus(1'b1, mls_pkg::MLS_CTRL_OFS, 32'h5);  // Allow off: no blocking
    wait_for(1'b0, 1'b1, 10);
    chk("alarm running", 1'b1, alarm_o);
    chk("not blocked", 1'b0, externally_blocked_flag_o);
    bus(1'b1, mls_pkg::MLS_CTRL_OFS, 32'h7);
    repeat (3) @(negedge clk_i);
    chk("blocked", 1'b1, externally_blocked_flag_o);
    chk("alarm blocked", 1'b0, alarm_o);
    chk("active blocked", 1'b0, active_o);
    chk("input two state", 1'b1, block_two_state_o);
    rchk(mls_pkg::MLS_STATE_OFS, 32'h32);
    @(posedge clk_i);
    external_block_input_one_i <= 1'b0;  // Input two stays high but unassigned
    wait_for(1'b0, 1'b1, 10);
    chk("unblocked", 1'b0, externally_blocked_flag_o);
    bus(1'b1, mls_pkg::MLS_CTRL_OFS, 32'hb);  // Input two now assigned
    @(negedge clk_i);
    chk("blocked two", 1'b1, externally_blocked_flag_o);
    rchk(mls_pkg::MLS_IRQ_STAT_OFS, 32'h9);
    $display("test run and block done");
  endtask : t_run_block

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_shed();
    t_run_block();
    print_verdict();
  end

  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #(100 * 20000);
    error_cnt++;
    $display("ERROR watchdog expected done seen timeout");
    print_verdict();
  end
endmodule : tb_mls_load_shed

bind mls_load_shed mls_load_shed_assertions i_mls_load_shed_assertions (
  .clk_i                      (clk_i),
  .rst_i                      (rst_i),
  .wb_cyc_i                   (wb_cyc_i),
  .wb_stb_i                   (wb_stb_i),
  .wb_ack_o                   (wb_ack_o),
  .wb_dat_o                   (wb_dat_o),
  .motor_running_i            (motor_running_i),
  .external_block_input_one_i (external_block_input_one_i),
  .external_block_input_two_i (external_block_input_two_i),
  .shed_contact_o             (shed_contact_o),
  .active_o                   (active_o),
  .externally_blocked_flag_o  (externally_blocked_flag_o),
  .alarm_o                    (alarm_o),
  .trip_o                     (trip_o),
  .block_one_state_o          (block_one_state_o),
  .block_two_state_o          (block_two_state_o)
);
